// [hbc_boot_seq.sv]
`timescale 1ns/10ps
`include "hbc_consts.svh"

module hbc_boot_seq
  import hbc_pkg::*;
(
  input  wire logic                   clock,              // 250 MHz core clock
  input  wire logic                   reset_n,            // Asynchronous reset
  input  wire logic [2:0]             fixed_port_select_pin,  // Resistor index
  input  wire logic [2:0]             charge_port_select_pin, // Resistor index
  input  wire logic [2:0]             preset_select_pin,  // Resistor index
  input  wire logic                   rom_strap,          // Serial ROM mode strap
  input  wire logic                   rom_dual_strap,     // Dual-bit ROM strap
  input  wire logic                   rom_mode3_strap,    // Mode 3 ROM strap
  input  wire logic                   mgmt_data_line_pu,  // Pull-up seen on data
  input  wire logic                   mgmt_clock_line_pu, // Pull-up seen on clock
  input  wire logic                   pll_locked,         // PLL lock level
  input  wire logic                   vbus_present,       // Upstream bus power
  input  wire logic [`HBC_GPIO_N-1:0] general_purpose_pin_in, // Pin levels
  output logic [`HBC_GPIO_N-1:0]      general_purpose_pin_out,  // Drive value
  output logic [`HBC_GPIO_N-1:0]      general_purpose_pin_oe_n, // Low drives
  output logic [`HBC_GPIO_N-1:0]      gpio_pull_up_en,    // Input pull-up
  output logic [`HBC_GPIO_N-1:0]      gpio_pull_down_en,  // Input pull-down
  output logic                        rom_rd_req,         // ROM byte request
  output logic [15:0]                 rom_rd_addr,        // ROM byte address
  input  wire logic                   rom_rd_ack,         // ROM byte valid pulse
  input  wire logic [7:0]             rom_rd_data,        // ROM byte
  output logic                        rom_dual_io,        // Dual-bit transfers
  output logic                        rom_mode3,          // Clock mode 3
  output logic                        ext_code_en,        // Run external code
  output logic [15:0]                 ext_code_addr,      // External start
  output logic                        mgmt_slave_mode,    // Slave when high
  input  wire logic                   smb_wr,             // Slave write strobe
  input  wire logic [7:0]             smb_addr,           // Slave register
  input  wire logic [7:0]             smb_wdata,          // Slave write data
  input  wire logic                   hfc_wr,             // Feature write strobe
  input  wire logic [7:0]             hfc_addr,           // Feature register
  input  wire logic [7:0]             hfc_wdata,          // Feature write data
  input  wire logic                   enumerated,         // Host configured hub
  input  wire logic [7:0]             rd_addr,            // Read register
  output logic [7:0]                  rd_data,            // Read data, 1 cycle
  output logic                        otp_merge_req,      // Merge one-time data
  input  wire logic                   otp_merge_done,     // Merge finished pulse
  input  wire logic                   chgdet_done,        // Detection finished
  output logic                        chgdet_run,         // Charger detection
  output logic                        hub_connect,        // Connect requested
  output logic                        ports_hiz,          // Ports high impedance
  output logic                        pll_run,            // PLL enabled
  output logic [4:0]                  fixed_ports,        // Ports 2..6 fixed
  output logic [5:0]                  charge_ports,       // Ports 1..6 charging
  output logic [3:0]                  boot_stage          // Current stage
);

  // ---------------------------------------------------------------
  // Decoders
  // ---------------------------------------------------------------
  function automatic logic [4:0] fixed_dec(input logic [2:0] idx);
    fixed_dec = 5'h00;
    for (int k = 0; k < 5; k++) begin
      if (idx > 3'(k) && idx < 3'h6) begin
        fixed_dec[k] = 1'b1;
      end
    end
  endfunction : fixed_dec

  function automatic logic [5:0] charge_dec(input logic [2:0] idx);
    case (idx)
      3'h1:    charge_dec = 6'h01;
      3'h2:    charge_dec = 6'h03;
      3'h3:    charge_dec = 6'h07;
      3'h4:    charge_dec = 6'h0f;
      3'h5:    charge_dec = 6'h3f;
      default: charge_dec = 6'h00;
    endcase
  endfunction : charge_dec

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hbc_state_s s_reg;
  hbc_state_s s_next;

  logic [`HBC_ASYNC_W-1:0] async_in;
  logic [2:0]              fixed_s;
  logic [2:0]              charge_s;
  logic [2:0]              preset_s;
  logic                    spi_s;
  logic                    dual_s;
  logic                    mode3_s;
  logic                    sda_pu_s;
  logic                    scl_pu_s;
  logic                    lock_s;
  logic                    vbus_s;
  logic [`HBC_GPIO_N-1:0]  gpin_s;
  logic                    smb_ok;
  logic                    hfc_ok;
  logic                    cfg_done;
  logic [31:0]             sig_new;

  assign async_in = {fixed_port_select_pin, charge_port_select_pin, preset_select_pin,
                     rom_strap, rom_dual_strap, rom_mode3_strap, mgmt_data_line_pu,
                     mgmt_clock_line_pu, pll_locked, vbus_present, general_purpose_pin_in};
  assign {fixed_s, charge_s, preset_s, spi_s, dual_s, mode3_s, sda_pu_s, scl_pu_s,
          lock_s, vbus_s, gpin_s} = s_reg.s2;

  // Slave writes reach the pins only once configuration or enumeration is under way.
  assign smb_ok   = smb_wr && (s_reg.stage == ST_EXT || s_reg.stage == ST_CONNECT);
  assign hfc_ok   = hfc_wr && enumerated && s_reg.stage == ST_CONNECT;
  assign cfg_done = smb_wr && s_reg.stage == ST_EXT && smb_addr == `HBC_CFG_DONE_OFF;
  assign sig_new  = {s_reg.sig[23:0], rom_rd_data};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       we;
    logic [7:0] a;
    logic [7:0] d;
    we        = 1'b0;
    a         = 8'h00;
    d         = 8'h00;
    s_next    = s_reg;
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;

    // Feature controller first so a same-cycle slave write takes priority.
    for (int p = 0; p < 2; p++) begin
      we = (p == 0) ? hfc_ok : smb_ok;
      a  = (p == 0) ? hfc_addr : smb_addr;
      d  = (p == 0) ? hfc_wdata : smb_wdata;
      if (we) begin
        case (a)
          `HBC_GPIO_DIR_OFF: s_next.gdir = d;
          `HBC_GPIO_OUT_OFF: s_next.gout = d;
          `HBC_GPIO_PEN_OFF: s_next.gpen = d;
          `HBC_GPIO_PUP_OFF: s_next.gpup = d;
          `HBC_FIXED_OFF: begin
            if (s_reg.stage == ST_EXT) begin
              s_next.fixed_mask = d[4:0];
            end
          end
          `HBC_CHARGE_OFF: begin
            if (s_reg.stage == ST_EXT) begin
              s_next.charge_mask = d[5:0];
            end
          end
          default: ;
        endcase
      end
    end

    case (rd_addr)
      `HBC_GPIO_DIR_OFF: s_next.rd_data = s_reg.gdir;
      `HBC_GPIO_OUT_OFF: s_next.rd_data = s_reg.gout;
      `HBC_GPIO_PEN_OFF: s_next.rd_data = s_reg.gpen;
      `HBC_GPIO_PUP_OFF: s_next.rd_data = s_reg.gpup;
      `HBC_GPIO_IN_OFF:  s_next.rd_data = gpin_s;
      `HBC_STAGE_OFF:    s_next.rd_data = {4'h0, s_reg.stage};
      `HBC_FIXED_OFF:    s_next.rd_data = {3'h0, s_reg.fixed_mask};
      `HBC_CHARGE_OFF:   s_next.rd_data = {2'h0, s_reg.charge_mask};
      default:           s_next.rd_data = 8'h00;
    endcase

    unique case (s_reg.stage)
      ST_STANDBY: begin
        s_next.stage = ST_INIT;
      end
      ST_INIT: begin
        // Pin levels are sampled through the synchroniser, after release.
        if (lock_s) begin
          s_next.fixed_idx   = fixed_s;
          s_next.charge_idx  = charge_s;
          s_next.preset_idx  = preset_s;
          s_next.spi_en      = spi_s;
          s_next.dual        = dual_s;
          s_next.mode3       = mode3_s;
          s_next.fixed_mask  = `HBC_FIXED_DEF;
          s_next.charge_mask = `HBC_CHARGE_DEF;
          s_next.cnt         = 2'h0;
          if (spi_s) begin
            s_next.stage   = ST_ROM;
            s_next.rom_req = 1'b1;
          end else begin
            s_next.stage = ST_CFG_RD;
          end
        end
      end
      ST_ROM: begin
        if (rom_rd_ack) begin
          s_next.sig = sig_new;
          s_next.cnt = s_reg.cnt + 2'h1;
          if (s_reg.cnt == `HBC_SIG_LAST) begin
            s_next.rom_req  = 1'b0;
            s_next.ext_boot = (sig_new == `HBC_SIG_WORD);
            s_next.stage    = ST_CFG_RD;
          end
        end
      end
      ST_CFG_RD: begin
        s_next.fixed_mask  = fixed_dec(s_reg.fixed_idx);
        s_next.charge_mask = charge_dec(s_reg.charge_idx);
        s_next.stage       = ST_STRAP;
      end
      ST_STRAP: begin
        s_next.slave_mode = (s_reg.preset_idx == `HBC_PRESET_SECOND);
        if (s_reg.preset_idx == `HBC_PRESET_SECOND && sda_pu_s && scl_pu_s) begin
          s_next.stage = ST_EXT;
        end else begin
          s_next.stage = ST_OTP;
        end
      end
      ST_EXT: begin
        // No timeout: only the final register write moves the boot on.
        if (cfg_done) begin
          s_next.stage = ST_OTP;
        end
      end
      ST_OTP: begin
        s_next.otp_req = 1'b1;
        if (otp_merge_done && s_reg.otp_req) begin
          s_next.otp_req = 1'b0;
          s_next.stage   = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (vbus_s) begin
          s_next.stage = (s_reg.charge_mask != 6'h00) ? ST_CHGDET : ST_CONNECT;
        end
      end
      ST_CHGDET: begin
        if (chgdet_done) begin
          s_next.stage = ST_CONNECT;
        end
      end
      ST_CONNECT: begin
        if (!vbus_s) begin
          s_next.stage = ST_IDLE;
        end
      end
      default: s_next.stage = ST_STANDBY;
    endcase
  end

  // ---------------------------------------------------------------
  // Register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_reg       <= '0;
      s_reg.stage <= ST_STANDBY;
      s_reg.gdir  <= `HBC_GPIO_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `HBC_GPIO_N; g++) begin : g_pin
      assign general_purpose_pin_out[g]  = s_reg.gout[g];
      assign general_purpose_pin_oe_n[g] = ~s_reg.gdir[g];
      assign gpio_pull_up_en[g]   = ~s_reg.gdir[g] & s_reg.gpen[g] & s_reg.gpup[g];
      assign gpio_pull_down_en[g] = ~s_reg.gdir[g] & s_reg.gpen[g] & ~s_reg.gpup[g];
    end
  endgenerate

  assign rom_rd_req      = s_reg.rom_req;
  assign rom_rd_addr     = `HBC_SIG_ADDR + {14'h0000, s_reg.cnt};
  assign rom_dual_io     = s_reg.dual;
  assign rom_mode3       = s_reg.mode3;
  assign ext_code_en     = s_reg.ext_boot;
  assign ext_code_addr   = `HBC_EXEC_ADDR;
  assign mgmt_slave_mode = s_reg.slave_mode;
  assign rd_data         = s_reg.rd_data;
  assign otp_merge_req   = s_reg.otp_req;
  assign chgdet_run      = s_reg.stage == ST_CHGDET;
  assign hub_connect     = s_reg.stage == ST_CONNECT;
  assign ports_hiz       = s_reg.stage != ST_CONNECT;
  assign pll_run         = s_reg.stage != ST_STANDBY;
  assign fixed_ports     = s_reg.fixed_mask;
  assign charge_ports    = s_reg.charge_mask;
  assign boot_stage      = s_reg.stage;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  standby_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_STANDBY |=> s_reg.stage == ST_INIT && pll_run)
    else $error("standby did not move to init");
  rom_skip_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_INIT && lock_s && !spi_s |=> s_reg.stage == ST_CFG_RD && !rom_rd_req)
    else $error("rom check not skipped");
  sig_match_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_ROM && rom_rd_ack && s_reg.cnt == 2'h3
    |=> ext_code_en == (s_reg.sig == 32'h32444655))
    else $error("signature result wrong");
  fixed_dec_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_CFG_RD && s_reg.fixed_idx == 3'h2 |=> fixed_ports == 5'h03)
    else $error("fixed port decode wrong");
  charge_dec_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_CFG_RD && s_reg.charge_idx == 3'h5 |=> charge_ports == 6'h3f)
    else $error("charge port decode wrong");
  ext_enter_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_STRAP |=> (s_reg.stage == ST_EXT) ==
    ($past(s_reg.preset_idx) == 3'h1 && $past(sda_pu_s) && $past(scl_pu_s)))
    else $error("external config entry wrong");
  ext_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_reg.stage == ST_EXT && !cfg_done |=> s_reg.stage == ST_EXT)
    else $error("external config left early");
  cfg_done_a: assert property (@(posedge clock) disable iff (!reset_n)
    cfg_done |=> s_reg.stage == ST_OTP ##1 otp_merge_req)
    else $error("final write did not end config");
  port_hiz_a: assert property (@(posedge clock) disable iff (!reset_n)
    !hub_connect |-> ports_hiz)
    else $error("ports driven outside connect");
  gpio_dir_a: assert property (@(posedge clock) disable iff (!reset_n)
    smb_ok && smb_addr == 8'h30 |=> general_purpose_pin_oe_n == ~$past(smb_wdata))
    else $error("pin direction write lost");

endmodule : hbc_boot_seq

// [hbc_consts.svh]
`ifndef HBC_CONSTS_SVH
`define HBC_CONSTS_SVH
`define HBC_GPIO_N        8
`define HBC_SIG_ADDR      16'hfffa
`define HBC_EXEC_ADDR     16'h0000
`define HBC_SIG_WORD      32'h32444655
`define HBC_SIG_LAST      2'h3
`define HBC_CFG_DONE_OFF  8'hff
`define HBC_GPIO_DIR_OFF  8'h30
`define HBC_GPIO_OUT_OFF  8'h31
`define HBC_GPIO_PEN_OFF  8'h32
`define HBC_GPIO_PUP_OFF  8'h33
`define HBC_GPIO_IN_OFF   8'h34
`define HBC_STAGE_OFF     8'h38
`define HBC_FIXED_OFF     8'h39
`define HBC_CHARGE_OFF    8'h3a
`define HBC_PRESET_SECOND 3'h1
`define HBC_FIXED_DEF     5'h00
`define HBC_CHARGE_DEF    6'h00
`define HBC_GPIO_RST      8'h00
`define HBC_ASYNC_W       24
`endif

// [hbc_pkg.sv]
package hbc_pkg;
  `include "hbc_consts.svh"

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h0,
    ST_INIT    = 4'h1,
    ST_ROM     = 4'h2,
    ST_CFG_RD  = 4'h3,
    ST_STRAP   = 4'h4,
    ST_EXT     = 4'h5,
    ST_OTP     = 4'h6,
    ST_IDLE    = 4'h7,
    ST_CHGDET  = 4'h8,
    ST_CONNECT = 4'h9
  } hbc_stage_e;

  typedef struct packed {
    hbc_stage_e                stage;
    logic [`HBC_ASYNC_W-1:0]   s1;
    logic [`HBC_ASYNC_W-1:0]   s2;
    logic [2:0]                fixed_idx;
    logic [2:0]                charge_idx;
    logic [2:0]                preset_idx;
    logic                      spi_en;
    logic                      dual;
    logic                      mode3;
    logic                      rom_req;
    logic [1:0]                cnt;
    logic [31:0]               sig;
    logic                      ext_boot;
    logic                      slave_mode;
    logic [4:0]                fixed_mask;
    logic [5:0]                charge_mask;
    logic [`HBC_GPIO_N-1:0]    gdir;
    logic [`HBC_GPIO_N-1:0]    gout;
    logic [`HBC_GPIO_N-1:0]    gpen;
    logic [`HBC_GPIO_N-1:0]    gpup;
    logic [7:0]                rd_data;
    logic                      otp_req;
  } hbc_state_s;
endpackage : hbc_pkg

// [hbc_rom_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Serial ROM stand-in that answers each byte request.
// ----------------------------------------------------------------
module hbc_rom_model (
  input  wire logic        clock,       // Core clock
  input  wire logic        reset_n,     // Asynchronous reset
  input  wire logic        rom_rd_req,  // Byte request
  input  wire logic [15:0] rom_rd_addr, // Byte address
  input  wire logic        corrupt,     // Spoil the last signature byte
  input  wire logic        slow,        // Answer after several cycles
  output logic             rom_rd_ack,  // Byte valid pulse
  output logic [7:0]       rom_rd_data  // Byte
);
  logic [2:0] wait_reg;
  logic [7:0] byte_at;
  // Stands for a 512 Kbit part that keeps up with the core clock while slow is low.
  always_comb begin
    case (rom_rd_addr)
      16'hfffa: byte_at = 8'h32;
      16'hfffb: byte_at = 8'h44;
      16'hfffc: byte_at = 8'h46;
      16'hfffd: byte_at = 8'h55;
      default:  byte_at = rom_rd_addr[7:0];
    endcase
  end
  // Data toggles outside the ack cycle, so a late sample never passes by luck.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rom_rd_ack  <= 1'b0;
      rom_rd_data <= 8'h00;
      wait_reg    <= 3'h0;
    end else if (rom_rd_req && !rom_rd_ack && wait_reg >= (slow ? 3'h5 : 3'h0)) begin
      rom_rd_ack  <= 1'b1;
      rom_rd_data <= byte_at ^ {7'h00, corrupt && rom_rd_addr == 16'hfffd};
      wait_reg    <= 3'h0;
    end else begin
      rom_rd_ack  <= 1'b0;
      rom_rd_data <= ~rom_rd_data;
      wait_reg    <= (rom_rd_req && !rom_rd_ack) ? wait_reg + 3'h1 : 3'h0;
    end
  end
endmodule : hbc_rom_model

// [hub_boot_config_sequencer_tb.sv]
`timescale 1ns/10ps
module hub_boot_config_sequencer_tb
  import hbc_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, partner and device
  // ----------------------------------------------------------------
  logic clock, reset_n, rom_strap, rom_dual_strap, rom_mode3_strap, pu_d, pu_c, corrupt, slow;
  logic pll_locked, vbus_present, smb_wr, hfc_wr, enumerated, otp_merge_done, chgdet_done;
  logic rom_rd_req, rom_rd_ack, rom_dual_io, rom_mode3, ext_code_en, mgmt_slave_mode;
  logic otp_merge_req, chgdet_run, hub_connect, ports_hiz, pll_run;
  logic [2:0] fix_idx, chg_idx, pre_idx;
  logic [7:0] gpi, gpo, oe_n, pu_en, pd_en, smb_addr, smb_wdata, hfc_addr, hfc_wdata;
  logic [7:0] rd_addr, rd_data, rom_rd_data;
  logic [15:0] rom_rd_addr, ext_code_addr, seen;
  logic [4:0] fixed_ports;
  logic [5:0] charge_ports;
  logic [3:0] boot_stage;
  int n_mismatch, n_checks;

  hbc_rom_model i_rom (.clock(clock), .reset_n(reset_n), .rom_rd_req(rom_rd_req),
    .rom_rd_addr(rom_rd_addr), .corrupt(corrupt), .slow(slow), .rom_rd_ack(rom_rd_ack),
    .rom_rd_data(rom_rd_data));
  hbc_boot_seq i_dut (.clock(clock), .reset_n(reset_n), .fixed_port_select_pin(fix_idx),
    .charge_port_select_pin(chg_idx), .preset_select_pin(pre_idx), .rom_strap(rom_strap),
    .rom_dual_strap(rom_dual_strap), .rom_mode3_strap(rom_mode3_strap),
    .mgmt_data_line_pu(pu_d), .mgmt_clock_line_pu(pu_c), .pll_locked(pll_locked),
    .vbus_present(vbus_present), .general_purpose_pin_in(gpi),
    .general_purpose_pin_out(gpo), .general_purpose_pin_oe_n(oe_n),
    .gpio_pull_up_en(pu_en), .gpio_pull_down_en(pd_en), .rom_rd_req(rom_rd_req),
    .rom_rd_addr(rom_rd_addr), .rom_rd_ack(rom_rd_ack), .rom_rd_data(rom_rd_data),
    .rom_dual_io(rom_dual_io), .rom_mode3(rom_mode3), .ext_code_en(ext_code_en),
    .ext_code_addr(ext_code_addr), .mgmt_slave_mode(mgmt_slave_mode), .smb_wr(smb_wr),
    .smb_addr(smb_addr), .smb_wdata(smb_wdata), .hfc_wr(hfc_wr), .hfc_addr(hfc_addr),
    .hfc_wdata(hfc_wdata), .enumerated(enumerated), .rd_addr(rd_addr), .rd_data(rd_data),
    .otp_merge_req(otp_merge_req), .otp_merge_done(otp_merge_done),
    .chgdet_done(chgdet_done), .chgdet_run(chgdet_run), .hub_connect(hub_connect),
    .ports_hiz(ports_hiz), .pll_run(pll_run), .fixed_ports(fixed_ports),
    .charge_ports(charge_ports), .boot_stage(boot_stage));

  always #2 clock = ~clock;

  // One-cycle done answers keep the far side honest without stalling the walk.
  always @(negedge clock) begin
    otp_merge_done <= otp_merge_req & ~otp_merge_done;
    chgdet_done    <= chgdet_run & ~chgdet_done;
    if (reset_n === 1'b1) seen[boot_stage] <= 1'b1;
  end

  task print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Wide enough for every packed compare, so no field is cut off unseen.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wait_st(input logic [3:0] s);
    for (int i = 0; i < 400 && boot_stage !== s; i++) @(negedge clock);
    chk(boot_stage, s);
    if (boot_stage !== s) print_verdict();
  endtask : wait_st

  task wr(input logic hf, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    if (hf) {hfc_wr, hfc_addr, hfc_wdata} = {1'b1, a, d};
    else {smb_wr, smb_addr, smb_wdata} = {1'b1, a, d};
    @(negedge clock);
    smb_wr = 1'b0;
    hfc_wr = 1'b0;
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    rd_addr = a;
    @(negedge clock);
    chk(rd_data, exp);
  endtask : rdchk

  task boot(input logic [2:0] f, c, p, input logic rs, d, k, cor, input logic [3:0] tgt);
    @(negedge clock);
    reset_n = 1'b0;
    {fix_idx, chg_idx, pre_idx, rom_strap, pu_d, pu_c, corrupt} = {f, c, p, rs, d, k, cor};
    {rom_dual_strap, rom_mode3_strap, slow} = {cor, ~cor, ~cor};
    repeat (16) @(negedge clock);
    chk({ports_hiz, pll_run, boot_stage}, {1'b1, 1'b0, ST_STANDBY});
    chk({oe_n, pu_en}, 16'hff00);
    seen = 16'h0000;
    reset_n = 1'b1;
    @(negedge clock);
    chk({pll_run, boot_stage}, {1'b1, ST_INIT});
    wait_st(tgt);
    chk({rom_dual_io, rom_mode3}, {cor, ~cor});
  endtask : boot

  initial begin
    {clock, reset_n, smb_wr, hfc_wr, enumerated, otp_merge_done, chgdet_done} = 7'h00;
    {pll_locked, vbus_present, gpi, rd_addr, smb_addr, smb_wdata, hfc_addr, hfc_wdata} = '0;
    {fix_idx, chg_idx, pre_idx, rom_strap, pu_d, pu_c, corrupt, slow} = '0;
    {rom_dual_strap, rom_mode3_strap, seen, n_mismatch, n_checks} = '0;
    pll_locked = 1'b1;
    vbus_present = 1'b1;
    gpi = 8'ha5;
    boot(3'h3, 3'h2, 3'h1, 1'b1, 1'b1, 1'b1, 1'b0, ST_EXT);
    chk({ext_code_en, ext_code_addr}, {1'b1, 16'h0000});
    chk({mgmt_slave_mode, fixed_ports, charge_ports}, {1'b1, 5'h07, 6'h03});
    wr(1'b0, 8'h30, 8'h0f);
    chk(oe_n, 8'hf0);
    wr(1'b0, 8'h31, 8'h05);
    wr(1'b0, 8'h32, 8'hf0);
    wr(1'b0, 8'h33, 8'h30);
    chk({gpo[3:0], pu_en, pd_en}, {4'h5, 8'h30, 8'hc0});
    rdchk(8'h34, 8'ha5);
    rdchk(8'h38, 8'h05);
    wr(1'b0, 8'h39, 8'h1f);
    chk(fixed_ports, 5'h1f);
    wr(1'b0, 8'hff, 8'h00);
    wait_st(ST_CONNECT);
    chk({seen[ST_OTP], seen[ST_CHGDET], hub_connect, ports_hiz}, 4'he);
    wr(1'b0, 8'h39, 8'h00);
    chk(fixed_ports, 5'h1f);
    rdchk(8'h39, 8'h1f);
    enumerated = 1'b1;
    wr(1'b1, 8'h30, 8'hff);
    chk(oe_n, 8'h00);
    wr(1'b0, 8'h31, 8'haa);
    chk(gpo, 8'haa);
    enumerated = 1'b0;
    wr(1'b1, 8'h31, 8'h00);
    chk(gpo, 8'haa);
    vbus_present = 1'b0;
    wait_st(ST_IDLE);
    vbus_present = 1'b1;
    for (int i = 0; i < 6; i++) begin
      boot(i[2:0], i[2:0], 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, ST_CONNECT);
      chk(fixed_ports, 5'((6'h01 << i) - 6'h01));
      chk(charge_ports, (i == 5) ? 6'h3f : 6'((7'h01 << i) - 7'h01));
      chk({ext_code_en, mgmt_slave_mode, seen[ST_ROM], seen[ST_EXT]}, 4'h0);
      chk(seen[ST_CHGDET], i != 0);
    end
    boot(3'h0, 3'h0, 3'h1, 1'b1, 1'b1, 1'b0, 1'b1, ST_CONNECT);
    chk({ext_code_en, seen[ST_ROM], seen[ST_EXT], mgmt_slave_mode}, 4'h5);
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end
endmodule : hub_boot_config_sequencer_tb
